// file: rtl/kiu_pkg.sv
// Constants shared by the keypad interrupt unit
package kiu_pkg;
    localparam int unsigned KEY_W         = 8;
    // Control write data field positions
    localparam int unsigned CTL_MODE_BIT  = 0;
    localparam int unsigned CTL_MASK_BIT  = 1;
    localparam int unsigned CTL_ACK_BIT   = 2;
    localparam int unsigned CTL_W         = 3;
    // Status readback field positions
    localparam int unsigned STS_MODE_BIT  = 0;
    localparam int unsigned STS_MASK_BIT  = 1;
    localparam int unsigned STS_ACK_BIT   = 2;
    localparam int unsigned STS_FLAG_BIT  = 3;
    localparam int unsigned STS_W         = 4;
    // Reset values
    localparam logic [KEY_W-1:0] RST_ENABLE = 8'h00;
    localparam logic [KEY_W-1:0] RST_SYNC   = 8'hff;
    localparam logic             RST_MODE   = 1'b0;
    localparam logic             RST_MASK   = 1'b0;
    localparam logic             RST_PREV   = 1'b1;
    localparam logic [STS_W-1:0] RST_STATUS = 4'h0;
endpackage

// file: rtl/kiu_sync.sv
// Two-stage synchroniser for the key pins
`timescale 1ns/1ps
module kiu_sync
    import kiu_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // Raw and synchronised pins
    input  wire logic [KEY_W-1:0] async_i,
    output logic      [KEY_W-1:0] sync_o
);
    logic [KEY_W-1:0] meta_ff;
    logic [KEY_W-1:0] sync_ff;

    // One synchroniser per pin; idle level is high so reset shows no low
    genvar g;
    generate
        for (g = 0; g < KEY_W; g++)
        begin : g_bit
            always_ff @(posedge mclk_i)
            begin
                if (rst_i)
                begin
                    meta_ff[g] <= RST_SYNC[g];
                    sync_ff[g] <= RST_SYNC[g];
                end
                else
                begin
                    meta_ff[g] <= async_i[g];
                    sync_ff[g] <= meta_ff[g];
                end
            end
        end
    endgenerate

    assign sync_o = sync_ff;
endmodule

// file: rtl/kiu_ack.sv
// Acknowledge pulse source with break-state gating
`timescale 1ns/1ps
module kiu_ack
(
    // Acknowledge sources
    input  wire logic vector_fetch_i,
    input  wire logic soft_ack_i,
    // Break control
    input  wire logic break_state_i,
    input  wire logic break_clear_enable_i,
    // Internal acknowledge
    output logic      ack_pulse_o
);
    logic soft_ok;

    // Software clear is blocked in break unless clearing is enabled
    assign soft_ok     = soft_ack_i & (~break_state_i | break_clear_enable_i);
    assign ack_pulse_o = vector_fetch_i | soft_ok;
endmodule

// file: rtl/kiu_top.sv
// Keypad interrupt unit: eight key pins, one shared maskable request
// Functional notes
// - Each pin enabled separately; enabling forces its pullup on.
// - Latch sets when an enabled input falls after all were high.
// - Edge mode ignores a fall while another enabled pin is low.
// - Edge-and-level mode keeps request while any enabled pin is low.
// - Level mode clears only after pins high and acknowledge, any order.
// - Vector fetch makes an acknowledge pulse that clears the latch.
// - Writing 1 to acknowledge bit makes the same pulse.
// - A fall after an acknowledge latches a new request.
// - Unmasked latched request raises the CPU interrupt.
// - Reset clears request and sense bit even with a pin low.
// - Sense bit 0: edge only, acknowledge clears at once.
// - Pending flag follows request, independent of mask.
// - Enabled pin forced to input; reads still need direction 0.
// - Unit active in wait and stop; unmasked request wakes.
// - In break, software clears allowed only with break clear enable 1; vector fetch clears in break regardless.
// - Break clear enable 0: accesses in break keep status.
// - Bit held through break is cleared by the step after.
// - Mask bit read/write; 1 blocks interrupts, 0 allows.
// - Sense bit read/write; 1 edge and level, 0 edge only.
// - Eight enable bits read/write; 1 includes pin, 0 excludes.
`timescale 1ns/1ps
module kiu_top
    import kiu_pkg::*;
(
    // Clock and reset
    input  wire logic             mclk_i,
    input  wire logic             rst_i,
    // Key pins and port settings
    input  wire logic [KEY_W-1:0] key_inputs_i,
    input  wire logic [KEY_W-1:0] port_pullup_enable_i,
    input  wire logic [KEY_W-1:0] port_dir_i,
    // Enable register write
    input  wire logic             enable_wr_i,
    input  wire logic [KEY_W-1:0] enable_wdata_i,
    // Status and control register write
    input  wire logic             ctrl_wr_i,
    input  wire logic [CTL_W-1:0] ctrl_wdata_i,
    // CPU and system state
    input  wire logic             vector_fetch_i,
    input  wire logic             break_state_i,
    input  wire logic             break_clear_enable_i,
    // Register readback
    output logic      [KEY_W-1:0] pin_enable_register_o,
    output logic      [STS_W-1:0] key_status_control_register_o,
    // Pin control
    output logic      [KEY_W-1:0] pullup_on_o,
    output logic      [KEY_W-1:0] pin_drive_en_o,
    output logic      [KEY_W-1:0] pin_read_ok_o,
    // Interrupt and wake
    output logic                  key_irq_o,
    output logic                  key_pending_flag_o,
    output logic                  wake_o,
    output logic                  stop_wake_o
);
    logic [KEY_W-1:0] key_sync;
    logic [KEY_W-1:0] pin_irq_enable_ff;
    logic             trigger_sense_bit_ff;
    logic             key_irq_mask_bit_ff;
    logic             prev_low_ff;
    logic             latch_ff;
    logic             any_low;
    logic             fall_evt;
    logic             soft_ack;
    logic             ack_pulse;
    logic             nxt_latch;
    logic             request;
    logic [KEY_W-1:0] pullup_ff;
    logic [KEY_W-1:0] drive_ff;
    logic [KEY_W-1:0] read_ok_ff;
    logic [STS_W-1:0] status_ff;
    logic             irq_ff;
    logic             flag_ff;
    logic             wake_ff;
    logic             stop_wake_ff;

    kiu_sync u_sync (
        .mclk_i  (mclk_i),
        .rst_i   (rst_i),
        .async_i (key_inputs_i),
        .sync_o  (key_sync)
    );

    assign soft_ack = ctrl_wr_i & ctrl_wdata_i[CTL_ACK_BIT];

    // fetch and software write share one pulse
    // break gating sits in the pulse source
    kiu_ack u_ack (
        .vector_fetch_i       (vector_fetch_i),
        .soft_ack_i           (soft_ack),
        .break_state_i        (break_state_i),
        .break_clear_enable_i (break_clear_enable_i),
        .ack_pulse_o          (ack_pulse)
    );

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            pin_irq_enable_ff <= RST_ENABLE;
        else if (enable_wr_i)
            pin_irq_enable_ff <= enable_wdata_i;
    end

    // sense bit; reset returns it to edge only
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            trigger_sense_bit_ff <= RST_MODE;
        else if (ctrl_wr_i)
            trigger_sense_bit_ff <= ctrl_wdata_i[CTL_MODE_BIT];
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            key_irq_mask_bit_ff <= RST_MASK;
        else if (ctrl_wr_i)
            key_irq_mask_bit_ff <= ctrl_wdata_i[CTL_MASK_BIT];
    end

    // Any enabled pin low; disabled pins never count
    assign any_low  = |(~key_sync & pin_irq_enable_ff);
    // shared fall only after all enabled pins were high
    // a second pin falling while one is low gives no event
    assign fall_evt = any_low & ~prev_low_ff;

    // Previous low state; reset as low, yet a pin held low through reset gives an event once enabled
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            prev_low_ff <= RST_PREV;
        else
            prev_low_ff <= any_low;
    end

    // Latch next state, set beats clear
    always_comb
    begin
        nxt_latch = latch_ff;
        // an acknowledge clears the latch at once in either mode
        // the low level is held outside the latch, see request
        if (ack_pulse)
            nxt_latch = 1'b0;
        // a fall in the acknowledge cycle still latches
        if (fall_evt)
            nxt_latch = 1'b1;
        // without clear enable a soft ack never arrives in break
        // the held bit clears on the acknowledge after break
    end

    // reset clears the request whatever the pins do
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            latch_ff <= 1'b0;
        else
            latch_ff <= nxt_latch;
    end

    // level mode keeps the request while any enabled pin is low
    // so an ack while low is not lost; pins high then drop it
    assign request = latch_ff | (trigger_sense_bit_ff & any_low);

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            irq_ff  <= 1'b0;
            flag_ff <= 1'b0;
            wake_ff <= 1'b0;
        end
        else
        begin
            irq_ff  <= request & ~key_irq_mask_bit_ff;
            flag_ff <= request;
            // wait-mode wake follows the unmasked request
            wake_ff <= request & ~key_irq_mask_bit_ff;
        end
    end

    // Stop-mode wake seen straight from the pins; flop holds it one cycle after the pins rise
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            stop_wake_ff <= 1'b0;
        else
            stop_wake_ff <= |(~key_inputs_i & pin_irq_enable_ff);
    end

    // enable forces pullup; enable forces input
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            pullup_ff  <= RST_ENABLE;
            drive_ff   <= RST_ENABLE;
            read_ok_ff <= RST_ENABLE;
        end
        else
        begin
            pullup_ff  <= pin_irq_enable_ff | port_pullup_enable_i;
            drive_ff   <= port_dir_i & ~pin_irq_enable_ff;
            read_ok_ff <= ~port_dir_i;
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            status_ff <= RST_STATUS;
        else
        begin
            status_ff               <= RST_STATUS;
            status_ff[STS_MODE_BIT] <= trigger_sense_bit_ff;
            status_ff[STS_MASK_BIT] <= key_irq_mask_bit_ff;
            status_ff[STS_ACK_BIT]  <= 1'b0;
            status_ff[STS_FLAG_BIT] <= request;
        end
    end

    assign pin_enable_register_o         = pin_irq_enable_ff;
    assign key_status_control_register_o = status_ff;
    assign pullup_on_o                   = pullup_ff;
    assign pin_drive_en_o                = drive_ff;
    assign pin_read_ok_o                 = read_ok_ff;
    assign key_irq_o                     = irq_ff;
    assign key_pending_flag_o            = flag_ff;
    assign wake_o                        = wake_ff;
    // clockless wake term for stop mode, unmasked
    assign stop_wake_o = (|(~key_inputs_i & pin_irq_enable_ff) & ~key_irq_mask_bit_ff)
                         | (stop_wake_ff & ~key_irq_mask_bit_ff);

    // Checks
    a_fall_sets: assert property (@(posedge mclk_i) disable iff (rst_i)
        fall_evt |=> latch_ff)
        else $error("fall did not set latch");
    a_second_fall: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!trigger_sense_bit_ff && prev_low_ff && !latch_ff) |=> !latch_ff)
        else $error("event while a pin was low");
    a_level_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        (trigger_sense_bit_ff && any_low) |=> key_pending_flag_o)
        else $error("level request dropped");
    a_edge_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!trigger_sense_bit_ff && vector_fetch_i && !fall_evt) |=> !latch_ff)
        else $error("edge ack failed to clear");
    a_soft_ack: assert property (@(posedge mclk_i) disable iff (rst_i)
        (soft_ack && !break_state_i && !trigger_sense_bit_ff && !fall_evt) |=> !latch_ff)
        else $error("soft ack failed");
    a_irq_mask: assert property (@(posedge mclk_i) disable iff (rst_i)
        key_irq_o |-> $past(request) && !$past(key_irq_mask_bit_ff))
        else $error("irq without unmasked request");
    a_flag_free: assert property (@(posedge mclk_i) disable iff (rst_i)
        latch_ff |=> key_pending_flag_o)
        else $error("flag missing");
    a_break_hold: assert property (@(posedge mclk_i) disable iff (rst_i)
        (break_state_i && !break_clear_enable_i && !vector_fetch_i && latch_ff)
        |=> latch_ff)
        else $error("status cleared in break");
    a_reset_clear: assert property (@(posedge mclk_i)
        rst_i |=> !latch_ff && !trigger_sense_bit_ff)
        else $error("reset left request");
    a_ack_zero: assert property (@(posedge mclk_i) disable iff (rst_i)
        !key_status_control_register_o[STS_ACK_BIT])
        else $error("ack bit read nonzero");
    a_pullup_on: assert property (@(posedge mclk_i) disable iff (rst_i)
        pin_irq_enable_ff[0] |=> pullup_on_o[0] && !pin_drive_en_o[0])
        else $error("pullup or input not forced");
    a_ack_clears: assert property (@(posedge mclk_i) disable iff (rst_i)
        (ack_pulse && !fall_evt) |=> !latch_ff)
        else $error("ack pulse left latch set");
    a_level_drop: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!latch_ff && !any_low) |=> !key_pending_flag_o)
        else $error("request kept with pins high and acked");
    a_mask_block: assert property (@(posedge mclk_i) disable iff (rst_i)
        key_irq_mask_bit_ff |=> !key_irq_o)
        else $error("masked request raised irq");
    a_wake_copy: assert property (@(posedge mclk_i) disable iff (rst_i)
        wake_o == key_irq_o)
        else $error("wake differs from irq");
    a_read_dir: assert property (@(posedge mclk_i) disable iff (rst_i)
        port_dir_i[0] |=> !pin_read_ok_o[0])
        else $error("read allowed on output pin");
    a_stop_wake: assert property (@(posedge mclk_i) disable iff (rst_i)
        (!key_inputs_i[0] && pin_irq_enable_ff[0] && !key_irq_mask_bit_ff) |-> stop_wake_o)
        else $error("stop wake missing");
    a_enable_excl: assert property (@(posedge mclk_i) disable iff (rst_i)
        (pin_irq_enable_ff == '0) |-> !fall_evt)
        else $error("event with no pin enabled");
endmodule

// file: dv/kiu_keys.sv
// Key switch model: pressed keys pull low, idle level set by pullup
`timescale 1ns/1ps
module kiu_keys
    import kiu_pkg::*;
(
    // Clock
    input  wire logic             mclk_i,
    // Pressed keys and pullup state
    input  wire logic [KEY_W-1:0] press_i,
    input  wire logic [KEY_W-1:0] pullup_i,
    // Pin levels
    output logic      [KEY_W-1:0] key_o
);
    logic [KEY_W-1:0] float_ff = '0;

    // A pin without pullup floats, so it wanders every cycle
    always @(posedge mclk_i)
    begin
        float_ff <= ~float_ff;
    end

    // Pressed key wins; otherwise pullup or a wandering level
    assign key_o = ~press_i & (pullup_i | float_ff);
endmodule

// file: dv/kiu_top_tb.sv
// Self-checking bench for the keypad interrupt unit
`timescale 1ns/1ps
module kiu_top_tb;
    import kiu_pkg::*;
    logic             mclk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic [KEY_W-1:0] press = '0;
    logic [KEY_W-1:0] key_inputs_i, port_pullup_enable_i = 8'hff, port_dir_i = '0;
    logic             enable_wr_i = 1'b0, ctrl_wr_i = 1'b0, vector_fetch_i = 1'b0;
    logic [KEY_W-1:0] enable_wdata_i = '0;
    logic [CTL_W-1:0] ctrl_wdata_i = '0;
    logic             break_state_i = 1'b0, break_clear_enable_i = 1'b0;
    logic [KEY_W-1:0] pin_enable_register_o, pullup_on_o, pin_drive_en_o, pin_read_ok_o;
    logic [STS_W-1:0] key_status_control_register_o;
    logic             key_irq_o, key_pending_flag_o, wake_o, stop_wake_o;
    int               failures = 0;
    int               checked = 0;
    int               cycles = 0;

    kiu_top i_dut (.mclk_i(mclk_i), .rst_i(rst_i), .key_inputs_i(key_inputs_i),
        .port_pullup_enable_i(port_pullup_enable_i), .port_dir_i(port_dir_i),
        .enable_wr_i(enable_wr_i), .enable_wdata_i(enable_wdata_i), .ctrl_wr_i(ctrl_wr_i),
        .ctrl_wdata_i(ctrl_wdata_i), .vector_fetch_i(vector_fetch_i),
        .break_state_i(break_state_i), .break_clear_enable_i(break_clear_enable_i),
        .pin_enable_register_o(pin_enable_register_o),
        .key_status_control_register_o(key_status_control_register_o),
        .pullup_on_o(pullup_on_o), .pin_drive_en_o(pin_drive_en_o),
        .pin_read_ok_o(pin_read_ok_o), .key_irq_o(key_irq_o),
        .key_pending_flag_o(key_pending_flag_o), .wake_o(wake_o), .stop_wake_o(stop_wake_o));

    kiu_keys i_keys (.mclk_i(mclk_i), .press_i(press), .pullup_i(pullup_on_o),
        .key_o(key_inputs_i));

    // 200 MHz clock
    initial
    begin
        forever #2.5 mclk_i = ~mclk_i;
    end

    // Hang guard, well above the length of all tests
    always @(posedge mclk_i)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            failures++;
            test_done();
        end
    end

    task automatic test_done();
        $display("checks %0d mismatches %0d", checked, failures);
        if (failures == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            failures++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // Compare {pending flag, interrupt}
    task automatic see(input logic [1:0] exp);
        chk({6'h00, key_pending_flag_o, key_irq_o}, {6'h00, exp});
    endtask

    // One-cycle write pulses; return once the readback has settled
    task automatic wr_ctl(input logic [2:0] d);
        ctrl_wdata_i = d;
        ctrl_wr_i = 1'b1;
        @(negedge mclk_i);
        ctrl_wr_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask

    task automatic wr_en(input logic [7:0] d);
        enable_wdata_i = d;
        enable_wr_i = 1'b1;
        @(negedge mclk_i);
        enable_wr_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask

    task automatic fetch();
        vector_fetch_i = 1'b1;
        @(negedge mclk_i);
        vector_fetch_i = 1'b0;
        repeat (2) @(negedge mclk_i);
    endtask

    // Key change, then wait past the four-edge request latency
    task automatic keys(input logic [7:0] p);
        press = p;
        repeat (5) @(negedge mclk_i);
    endtask

    task automatic endt(input string s);
        $display("test %s done", s);
    endtask

    initial
    begin
        repeat (20) @(negedge mclk_i);
        rst_i = 1'b0;
        chk({4'h0, key_status_control_register_o}, 8'h00);
        chk(pin_enable_register_o, 8'h00);
        port_pullup_enable_i = 8'h00;
        port_dir_i = 8'hf0;
        // mask before enabling pins that have no port pullup
        wr_ctl(3'b011);
        wr_en(8'h3c);
        // level mode waits for the pullups before acknowledging
        keys(8'h00);
        wr_ctl(3'b111);
        chk(pin_enable_register_o, 8'h3c);
        chk(pullup_on_o, 8'h3c);
        chk(pin_drive_en_o, 8'hc0);
        chk(pin_read_ok_o, 8'h0f);
        chk({4'h0, key_status_control_register_o}, 8'h03);
        port_pullup_enable_i = 8'hff;
        port_dir_i = 8'h00;
        endt("registers");
        wr_en(8'h0f);
        wr_ctl(3'b110);
        wr_ctl(3'b000);
        see(2'b00);
        keys(8'h01);
        see(2'b11);
        chk({7'h00, stop_wake_o}, 8'h01);
        wr_ctl(3'b100);
        see(2'b00);
        keys(8'h03);
        see(2'b00);
        keys(8'h00);
        keys(8'h04);
        see(2'b11);
        fetch();
        see(2'b00);
        keys(8'h10);
        see(2'b00);
        keys(8'h00);
        endt("edge");
        wr_ctl(3'b010);
        keys(8'h01);
        see(2'b10);
        chk({6'h00, wake_o, stop_wake_o}, 8'h00);
        wr_ctl(3'b000);
        see(2'b11);
        chk({7'h00, wake_o}, 8'h01);
        fetch();
        see(2'b00);
        keys(8'h00);
        endt("mask");
        wr_ctl(3'b001);
        keys(8'h02);
        see(2'b11);
        wr_ctl(3'b101);
        see(2'b11);
        keys(8'h00);
        see(2'b00);
        keys(8'h02);
        keys(8'h00);
        see(2'b11);
        // acknowledge before leaving the service routine
        wr_ctl(3'b101);
        see(2'b00);
        endt("level");
        wr_ctl(3'b000);
        keys(8'h01);
        keys(8'h00);
        break_state_i = 1'b1;
        wr_ctl(3'b100);
        see(2'b11);
        break_state_i = 1'b0;
        wr_ctl(3'b100);
        see(2'b00);
        keys(8'h01);
        keys(8'h00);
        break_state_i = 1'b1;
        break_clear_enable_i = 1'b1;
        wr_ctl(3'b100);
        see(2'b00);
        break_state_i = 1'b0;
        break_clear_enable_i = 1'b0;
        repeat (3) @(negedge mclk_i);
        see(2'b00);
        endt("break");
        wr_ctl(3'b001);
        keys(8'h01);
        rst_i = 1'b1;
        repeat (2) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (5) @(negedge mclk_i);
        see(2'b00);
        chk({4'h0, key_status_control_register_o}, 8'h00);
        endt("reset");
        test_done();
    end
endmodule
